// *** ascr_pkg.sv ***
`default_nettype none
package ascr_pkg;
  // Frame geometry
  localparam int FRAME_BITS = 16;
  localparam int CFG_BITS = 12;
  localparam int DATA_BITS = 12;
  // Configuration field positions
  localparam int POS_WRITE = 11;
  localparam int POS_SEQ_HI = 10;
  localparam int POS_ADDR_HI = 7;
  localparam int POS_ADDR_LO = 6;
  localparam int POS_PM_HI = 5;
  localparam int POS_PM_LO = 4;
  localparam int POS_SEQ_LO = 3;
  localparam int POS_RANGE = 1;
  localparam int POS_CODING = 0;
  // Value after reset: normal power, straight binary, channel 0
  localparam logic [11:0] CFG_RESET = 12'h031;
  // Decoded configuration
  typedef struct packed {
    logic sequence_select_high;
    logic sequence_select_low;
    logic [1:0] channel;
    logic [1:0] power_mode;
    logic range;
    logic coding;
  } ascr_cfg_t;
endpackage : ascr_pkg
`default_nettype wire

// *** ascr_sync.sv ***
`default_nettype none
// Two-flop synchroniser for pin inputs
module ascr_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  // First stage, read only by the second
  logic [WIDTH-1:0] meta;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= INIT;
      q <= INIT;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule : ascr_sync
`default_nettype wire

// *** ascr_core.sv ***
`default_nettype none
// Operation
// - Twelve-bit configuration, write only, never read
// - Sample input on falling serial clock edge
// - Shift config in while result shifts out
// - New configuration applies to following conversion
// - Capture only first twelve falling edges
// - Most significant bit first into bit eleven
// - Field order fixed from write flag down
// - Write flag zero keeps register unchanged
// - Channel address selects input zero to three
// - Coding zero twos complement, one binary
// - Output two zeros, address, data, padding
module ascr_core #(
  parameter int RES_BITS = 12
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  input wire logic [RES_BITS-1:0] sample,
  output logic dout,
  output logic conv_start,
  output ascr_pkg::ascr_cfg_t cfg,
  output logic [1:0] mux_channel
);
  import ascr_pkg::*;

  // Elaboration guard: the coding flip needs at least two result bits
  if (RES_BITS < 2 || RES_BITS > DATA_BITS) begin : g_res_check
    $error("RES_BITS out of range");
  end

  // Synchronised pins
  // One shared synchroniser keeps clock and data aligned to each other
  logic sclk_s, cs_n_s, din_s;
  ascr_sync #(.WIDTH(3), .INIT(3'h6)) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d({sclk, cs_n, din}),
    .q({sclk_s, cs_n_s, din_s})
  );

  // Previous levels for edge detection
  logic sclk_d, cs_n_d;
  logic fall_sclk, cs_fall, cs_rise;
  // Falling serial clock only counts while selected
  assign fall_sclk = sclk_d & ~sclk_s & ~cs_n_s;
  assign cs_fall = cs_n_d & ~cs_n_s;
  assign cs_rise = ~cs_n_d & cs_n_s;

  // Frame state
  logic [4:0] edge_cnt, next_edge_cnt;
  logic [11:0] shift_in, next_shift_in;
  logic [15:0] shift_out, next_shift_out;
  logic [11:0] creg, next_creg;
  logic next_dout, next_conv_start;
  // Setup frozen for the running conversion
  logic [1:0] conv_ch, next_conv_ch;
  logic conv_coding, next_conv_coding;

  // Converted word for the frame being opened, coding applied
  function automatic logic [15:0] build_frame(input logic [1:0] ch,
                                              input logic code_bin,
                                              input logic [RES_BITS-1:0] s);
    logic [DATA_BITS-1:0] d;
    // Narrower results leave trailing zeros as padding
    d = '0;
    // Twos complement flips the MSB of offset binary
    d[DATA_BITS-1 -: RES_BITS] = code_bin ? s : {~s[RES_BITS-1], s[RES_BITS-2:0]};
    build_frame = {2'b00, ch, d};
  endfunction

  // Next-state logic
  always_comb begin
    next_edge_cnt = edge_cnt;
    next_shift_in = shift_in;
    next_shift_out = shift_out;
    next_creg = creg;
    next_dout = dout;
    next_conv_start = 1'b0;
    next_conv_ch = conv_ch;
    next_conv_coding = conv_coding;
    if (cs_fall) begin
      // Sample at chip select fall uses the configuration already held
      next_edge_cnt = '0;
      next_conv_start = 1'b1;
      next_conv_ch = creg[POS_ADDR_HI:POS_ADDR_LO];
      next_conv_coding = creg[POS_CODING];
      next_shift_out = build_frame(creg[POS_ADDR_HI:POS_ADDR_LO], creg[POS_CODING],
                                   sample);
      next_dout = 1'b0;
    end else if (fall_sclk && edge_cnt < 5'(FRAME_BITS)) begin
      // Counter stops at sixteen; extra edges change nothing
      next_edge_cnt = edge_cnt + 5'd1;
      if (edge_cnt < 5'(CFG_BITS)) begin
        next_shift_in = {shift_in[10:0], din_s};
      end
      // Output advances on the same edge that input is sampled
      next_shift_out = {shift_out[14:0], 1'b0};
      next_dout = shift_out[14];
      if (edge_cnt == 5'(CFG_BITS - 1) && shift_in[10]) begin
        // Write flag is the first bit, now at bit 10 before the shift
        next_creg = {1'b1, shift_in[9:0], din_s};
      end
    end
    if (cs_rise) begin
      // Frame over; stop driving meaningful data
      next_dout = 1'b0;
    end
  end

  // State registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      // Idle pin levels, so no false edge follows reset
      sclk_d <= 1'b1;
      cs_n_d <= 1'b1;
      edge_cnt <= '0;
      shift_in <= '0;
      shift_out <= '0;
      creg <= CFG_RESET;
      dout <= 1'b0;
      conv_start <= 1'b0;
      conv_ch <= CFG_RESET[POS_ADDR_HI:POS_ADDR_LO];
      conv_coding <= CFG_RESET[POS_CODING];
    end else begin
      sclk_d <= sclk_s;
      cs_n_d <= cs_n_s;
      edge_cnt <= next_edge_cnt;
      shift_in <= next_shift_in;
      shift_out <= next_shift_out;
      creg <= next_creg;
      dout <= next_dout;
      conv_start <= next_conv_start;
      conv_ch <= next_conv_ch;
      conv_coding <= next_conv_coding;
    end
  end

  // Decoded configuration outputs, registered
  ascr_cfg_t next_cfg;
  always_comb begin
    next_cfg.sequence_select_high = creg[POS_SEQ_HI];
    next_cfg.sequence_select_low = creg[POS_SEQ_LO];
    next_cfg.channel = creg[POS_ADDR_HI:POS_ADDR_LO];
    next_cfg.power_mode = creg[POS_PM_HI:POS_PM_LO];
    next_cfg.range = creg[POS_RANGE];
    next_cfg.coding = creg[POS_CODING];
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg <= '0;
      mux_channel <= '0;
    end else begin
      cfg <= next_cfg;
      // Channel follows the conversion start by one cycle
      mux_channel <= conv_ch;
    end
  end

  // Frame length depends on the host; counter saturates at sixteen
  frame_cap_a: assert property (@(posedge clk) disable iff (!rst_n)
    edge_cnt <= 5'(FRAME_BITS)) else $error("edge count passed frame");

  write_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
    (fall_sclk && !cs_fall && edge_cnt == 5'd11 && !shift_in[10])
    |=> $stable(creg)) else $error("register changed without write");

  write_load_a: assert property (@(posedge clk) disable iff (!rst_n)
    (fall_sclk && !cs_fall && edge_cnt == 5'd11 && shift_in[10])
    |=> creg == {1'b1, $past(shift_in[9:0]), $past(din_s)})
    else $error("register not loaded");

  late_ignore_a: assert property (@(posedge clk) disable iff (!rst_n)
    (edge_cnt > 5'd11 && !cs_fall) |=> $stable(shift_in))
    else $error("late bit captured");

  creg_only_a: assert property (@(posedge clk) disable iff (!rst_n)
    !(fall_sclk && edge_cnt == 5'd11) && !cs_fall |=> $stable(creg))
    else $error("register changed off the twelfth edge");

  lead_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
    cs_fall |=> !dout && shift_out[15:14] == 2'b00)
    else $error("frame lacks leading zeros");

  next_conv_a: assert property (@(posedge clk) disable iff (!rst_n)
    cs_fall |=> conv_ch == $past(creg[POS_ADDR_HI:POS_ADDR_LO])
    ##1 mux_channel == $past(conv_ch))
    else $error("wrong channel taken");

  shift_sync_a: assert property (@(posedge clk) disable iff (!rst_n)
    (fall_sclk && !cs_fall && edge_cnt < 5'd12) |=> edge_cnt == $past(edge_cnt) + 5'd1)
    else $error("shift count stalled");

  sample_edge_a: assert property (@(posedge clk) disable iff (!rst_n)
    (!fall_sclk && !cs_fall) |=> $stable(shift_in))
    else $error("bit sampled off falling edge");

  // Result bits move only on a falling edge or at frame bounds
  dout_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    (!fall_sclk && !cs_fall && !cs_rise) |=> $stable(dout))
    else $error("result bit moved off an edge");

  // After sixteen edges only padding zeros remain to shift
  pad_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
    edge_cnt == 5'(FRAME_BITS) |-> shift_out == 16'h0000)
    else $error("frame not padded with zeros");

  // One conversion start per detected chip select fall
  start_pulse_a: assert property (@(posedge clk) disable iff (!rst_n)
    cs_fall |=> conv_start ##1 !conv_start)
    else $error("conversion start not a single pulse");

  // Decoded fields follow the stored word one cycle later
  cfg_track_a: assert property (@(posedge clk) disable iff (!rst_n)
    1'b1 |=> cfg.channel == $past(creg[POS_ADDR_HI:POS_ADDR_LO])
    && cfg.coding == $past(creg[POS_CODING]))
    else $error("decoded fields lag the register");

endmodule : ascr_core
`default_nettype wire

// *** ascr_host.sv ***
`default_nettype none
// Host serial master: drives whole sixteen-clock frames
module ascr_host (
  output logic sclk,
  output logic cs_n,
  output logic din,
  input wire logic dout
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int HALF = 160; // Half of the 320 ns link clock
  // Idle: clock high, deselected
  initial begin
    sclk = 1'b1;
    cs_n = 1'b1;
    din = 1'b0;
  end
  // One frame: config bits go out while result bits come back
  task automatic frame(input logic [15:0] tx, output logic [15:0] rx);
    cs_n = 1'b0;
    #HALF;
    for (int k = 15; k >= 0; k--) begin
      din = tx[k];
      #HALF;
      rx[k] = dout;
      sclk = 1'b0;
      #HALF;
      sclk = 1'b1;
    end
    #HALF;
    cs_n = 1'b1;
    // Released line shows the inverse so a stale bit cannot pass
    din = ~din;
    // Deselected gap long enough for the block to see the rising edge
    #(2 * HALF);
  endtask
endmodule // ascr_host
`default_nettype wire

// *** tb_adc_serial_control_register.sv ***
`default_nettype none
// Compare, count, report at once
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("unexpected at %0t: got %h exp %h", $time, (g), (e)); end end
module tb_adc_serial_control_register;
  timeunit 1ns;
  timeprecision 100ps;
  import ascr_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [11:0] sample = 12'h8a5; // Raw result, offset binary
  logic sclk, cs_n, din, dout, conv_start;
  ascr_cfg_t cfg;
  logic [1:0] mux_channel;
  logic [15:0] rx; // Result word seen by the host
  logic [1:0] prev; // Channel of the conversion being read
  int fail_count = 0;
  int total_checks = 0;
  int cycles = 0;
  int starts = 0; // Conversion start pulses seen
  ascr_core i_ascr_core (.clk(clk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .din(din),
    .sample(sample), .dout(dout), .conv_start(conv_start), .cfg(cfg),
    .mux_channel(mux_channel));
  ascr_host i_ascr_host (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout));
  // 25 MHz system clock
  always #20 clk = ~clk;
  // Expected decode of a twelve-bit word
  function automatic ascr_cfg_t exp_cfg(input logic [11:0] w);
    exp_cfg = '{w[POS_SEQ_HI], w[POS_SEQ_LO], w[POS_ADDR_HI:POS_ADDR_LO],
      w[POS_PM_HI:POS_PM_LO], w[POS_RANGE], w[POS_CODING]};
  endfunction
  // Verdict and end of run
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Pulse count and hang guard; frames take about 150 cycles
  always @(posedge clk) begin
    cycles++;
    if (conv_start === 1'b1) starts++;
    if (cycles == 4000) begin
      fail_count++;
      results();
    end
  end
  // Main sequence
  initial begin
    repeat (3) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (2) @(posedge clk);
    // Look at settled outputs and start link traffic off the edge
    #1;
    `CHK(cfg, exp_cfg(CFG_RESET))
    `CHK(mux_channel, 2'h0)
    // Write ch2; trailing ones must not shift in
    i_ascr_host.frame({12'hc92, 4'hf}, rx);
    `CHK(rx, 16'h08a5)
    `CHK(cfg, exp_cfg(12'hc92))
    @(posedge clk) #1 sample = 12'h3c0;
    // Write flag clear: all else ignored
    i_ascr_host.frame({12'h7ff, 4'h0}, rx);
    `CHK(rx, 16'h2bc0)
    `CHK(cfg, exp_cfg(12'hc92))
    `CHK(mux_channel, 2'h2)
    prev = 2'h2;
    // Walk every channel, each read back one frame later
    for (int c = 0; c < 5; c++) begin
      i_ascr_host.frame({4'h8, 2'(c), 6'h31, 4'h0}, rx);
      `CHK(rx[15:12], {2'b00, prev})
      `CHK(cfg, exp_cfg({4'h8, 2'(c), 6'h31}))
      prev = 2'(c);
    end
    `CHK(rx[11:0], 12'h3c0)
    `CHK(starts, 7)
    // Reset in mid-run restores the default configuration
    @(posedge clk) #1 rst_n = 1'b0;
    repeat (3) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    `CHK(cfg, exp_cfg(CFG_RESET))
    i_ascr_host.frame(16'h0000, rx);
    `CHK(rx, 16'h03c0)
    `CHK(cfg, exp_cfg(CFG_RESET))
    results();
  end
endmodule // tb_adc_serial_control_register
`default_nettype wire
